// >>> common/dci_pkg.sv
// Constants and types shared by both ends of the DRAM command link
// Behaviour
// [RQ1] Sample all inputs at the rising clock edge
// [RQ2] Reads edge-aligned strobe, writes centred strobe
// [RQ3] Chip select plus three strobes form command
// [RQ4] Chip select high masks every command
// [RQ5] Row on activate, column on access, bit10 autoclose
// [RQ6] Precharge closes one bank, all if bit10
// [RQ7] Load-mode takes op code from address
// [RQ8] Bank address picks one of eight banks
// [RQ9] Bank address picks one of four mode registers
// [RQ10] On-the-fly chop: bit12 high eight, low four
// [RQ11] Registered clock enable gates internal logic
// [RQ12] Clock enable low: power-down or self refresh
// [RQ13] Self-refresh exit seen without the clock
// [RQ14] Receivers off in power-down and self refresh; the termination input stays live in power-down
// [RQ15] Lower mask high drops lower byte
// [RQ16] Termination input switches data-side termination
// [RQ17] Termination input ignored when mode disables it
// [RQ18] Termination strobe option disables eight-bit mask
// [RQ19] Upper balls unused in four-bit configuration
// [RQ20] Active-low reset acts without the clock
// [RQ21] Upper mask high drops upper byte
// [RQ22] Each byte lane has its own strobe
// [RQ23] Without on-the-fly chop, mode burst length rules
package dci_pkg;
  // ==========================================
  // Link widths
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int NBANK = 8;
  localparam int NMR = 4;
  localparam int MEM_AW = 9;
  // ==========================================
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // ==========================================
  // Address and mode fields
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BL_MSB = 1;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  localparam int MR1_RTT0 = 2;
  localparam int MR1_RTT1 = 6;
  localparam int MR1_RTT2 = 9;
  localparam int MR1_TDQS = 11;
  localparam logic [1:0] MR0_IDX = 2'h0;
  localparam logic [1:0] MR1_IDX = 2'h1;
  localparam logic [2:0] LAST_BL8 = 3'h7;
  localparam logic [2:0] LAST_BC4 = 3'h3;
  localparam logic [2:0] RD_LAT = 3'h2;
  localparam logic [2:0] WR_LAT = 3'h1;
  localparam logic [15:0] MASK_X4 = 16'h000F;
  localparam logic [15:0] MASK_X8 = 16'h00FF;
  localparam logic [15:0] MASK_X16 = 16'hFFFF;
  // ==========================================
  // Controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int CTRL_CKE = 0;
  localparam int CTRL_ODT = 1;
  localparam int CTRL_RSTN = 2;
  localparam int CTRL_DM0 = 3;
  localparam int CTRL_DM1 = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int ADDR_BA_LSB = 16;
  localparam int RDATA_CNT_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [3:0] BURST_MAX = 4'h8;
  localparam logic [4:0] RD_WIN = 5'h10;
  // ==========================================
  // Types
  typedef enum logic [1:0] {WID_X4, WID_X8, WID_X16} dci_width_t;
  typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SR} dci_pwr_t;
endpackage

// >>> common/dci_if.sv
// Link between the controller and the DRAM device
interface dci_if;
  import dci_pkg::*;
  logic reset_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] dm;
  logic [DQ_W-1:0] c_dq;
  logic [DQ_W-1:0] c_dq_oe_n;
  logic [LANES-1:0] c_dqs;
  logic [LANES-1:0] c_dqs_oe_n;
  logic [DQ_W-1:0] d_dq;
  logic [DQ_W-1:0] d_dq_oe_n;
  logic [LANES-1:0] d_dqs;
  logic [LANES-1:0] d_dqs_oe_n;
  // Resolved wire levels; device drive wins, undriven reads as zero
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] dqs;
  assign dq = (d_dq & ~d_dq_oe_n) | (c_dq & ~c_dq_oe_n & d_dq_oe_n);
  assign dqs = (d_dqs & ~d_dqs_oe_n) | (c_dqs & ~c_dqs_oe_n & d_dqs_oe_n);
  modport ctl (
    output reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
    output c_dq, c_dq_oe_n, c_dqs, c_dqs_oe_n,
    input dq, dqs, d_dq_oe_n, d_dqs_oe_n
  );
  modport dev (
    input reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm,
    input dq, dqs,
    output d_dq, d_dq_oe_n, d_dqs, d_dqs_oe_n
  );
endinterface

// >>> hw/dci_ctrl.sv
// Memory controller end: register port in, command link out
module dci_ctrl
  import dci_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  dci_if.ctl link
);
  typedef enum logic [2:0] {C_IDLE, C_CMD, C_WLAT, C_WDAT, C_RWAIT} dci_cst_t;

  // ==========================================
  // Register decode
  logic wr_ctrl, wr_addr, wr_cmd, wr_wdat, rd_stat, busy, done_set;
  logic [31:0] rd_mux;
  logic [4:0] ctrl;
  logic [ADDR_W-1:0] adr;
  logic [BA_W-1:0] bank;
  logic [15:0] wdat, rdat;
  logic [3:0] rcnt, beat;
  logic [3:0] code;
  logic [4:0] cnt;
  logic done;
  dci_cst_t st;

  assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
  assign wr_addr = i_wr && (i_addr == REG_ADDR);
  assign wr_cmd = i_wr && (i_addr == REG_CMD) && !busy;
  assign wr_wdat = i_wr && (i_addr == REG_WDATA);
  assign rd_stat = i_rd && (i_addr == REG_STATUS);
  assign busy = (st != C_IDLE);
  assign done_set = (st == C_RWAIT) && (cnt == '0);
  assign rd_mux = (i_addr == REG_CTRL) ? {27'h000_0000, ctrl} :
                  (i_addr == REG_ADDR) ? {13'h0000, bank, 2'h0, adr} :
                  (i_addr == REG_WDATA) ? {16'h0000, wdat} :
                  (i_addr == REG_RDATA) ? {12'h000, rcnt, rdat} :
                  (i_addr == REG_STATUS) ? {30'h0000_0000, done, busy} : 32'h0000_0000;

  // ==========================================
  // Software registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl <= CTRL_RST;
      adr <= '0;
      bank <= '0;
      wdat <= '0;
      code <= CMD_NOP;
      done <= 1'b0;
      o_rdata <= '0;
    end else begin
      if (wr_ctrl) ctrl <= i_wdata[4:0];
      if (wr_addr) adr <= i_wdata[ADDR_W-1:0];
      if (wr_addr) bank <= i_wdata[ADDR_BA_LSB +: BA_W];
      if (wr_wdat) wdat <= i_wdata[15:0];
      if (wr_cmd) code <= i_wdata[3:0];
      // A finishing read beats a status read in the same cycle
      done <= done_set || (done && !rd_stat);
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // ==========================================
  // Pins held straight from control bits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link.reset_n <= 1'b0;
      link.cke <= 1'b0;
      link.odt <= 1'b0;
      link.dm <= '0;
    end else begin
      link.reset_n <= ctrl[CTRL_RSTN]; // [RQ20]
      link.cke <= ctrl[CTRL_CKE]; // [RQ12] [RQ13]
      link.odt <= ctrl[CTRL_ODT];
      link.dm <= {ctrl[CTRL_DM1], ctrl[CTRL_DM0]};
    end
  end

  // ==========================================
  // Command and burst sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= C_IDLE;
      cnt <= '0;
      beat <= '0;
      rcnt <= '0;
      rdat <= '0;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP | 4'h8;
      link.addr <= '0;
      link.ba <= '0;
      link.c_dq <= '0;
      link.c_dq_oe_n <= '1;
      link.c_dqs <= '0;
      link.c_dqs_oe_n <= '1;
    end else begin
      case (st)
        C_IDLE: begin
          if (wr_cmd) begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= i_wdata[3:0];
            link.addr <= adr;
            link.ba <= bank;
            st <= C_CMD;
          end
        end
        C_CMD: begin
          {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP | 4'h8;
          if (code == CMD_WR) begin
            // First beat must sit on the pins WR_LAT edges after the command
            st <= (WR_LAT > 3'h1) ? C_WLAT : C_WDAT;
            cnt <= {2'h0, WR_LAT - 3'h2};
            beat <= '0;
          end else if (code == CMD_RD) begin
            st <= C_RWAIT;
            cnt <= RD_WIN;
            rcnt <= '0;
          end else begin
            st <= C_IDLE;
          end
        end
        C_WLAT: begin
          if (cnt == '0) begin
            st <= C_WDAT;
            beat <= '0;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        C_WDAT: begin
          // Strobe high across a full stable data cycle stands for centring
          if (beat == BURST_MAX) begin
            link.c_dq_oe_n <= '1;
            link.c_dqs <= '0;
            link.c_dqs_oe_n <= '1;
            st <= C_IDLE;
          end else begin
            link.c_dq <= wdat + {12'h000, beat};
            link.c_dq_oe_n <= '0;
            link.c_dqs <= '1; // [RQ2] [RQ22]
            link.c_dqs_oe_n <= '0;
            beat <= beat + 4'h1;
          end
        end
        C_RWAIT: begin
          if (!link.d_dq_oe_n[0]) begin
            if (rcnt == '0) rdat <= link.dq;
            rcnt <= rcnt + 4'h1;
          end
          if (cnt == '0) st <= C_IDLE;
          else cnt <= cnt - 5'h01;
        end
        default: st <= C_IDLE;
      endcase
    end
  end
endmodule

// >>> hw/dci_device.sv
// DRAM device end: command decode, banks, mode registers, power, data
module dci_device
  import dci_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dci_width_t i_width,
  dci_if.dev link,
  output dci_pwr_t o_pwr,
  output logic [NBANK-1:0] o_open_banks,
  output logic o_term_on,
  output logic o_tdqs_term
);
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_RD, B_WR} dci_bst_t;

  // ==========================================
  // State
  dci_pwr_t pwr, next_pwr;
  dci_bst_t bst, next_bst;
  logic [NBANK-1:0] open_banks, next_open;
  logic [NBANK-1:0] row_tag;
  logic [ADDR_W-1:0] mode_reg [NMR];
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic [2:0] lat, next_lat, beat, next_beat, last, next_last;
  logic [BA_W-1:0] bbank, next_bbank;
  logic [4:0] bcol, next_bcol;
  logic bap, next_bap, bdir, next_bdir;
  logic sr_wake;
  logic term_q, tdqs_q;

  // ==========================================
  // Command decode at the rising edge
  logic [3:0] cmd_code;
  logic rx_on, cmd_ok;
  logic is_mrs, is_act, is_pre, is_rd, is_wr, enter_sr, no_open;
  assign cmd_code = {link.cs_n, link.ras_n, link.cas_n, link.we_n}; // [RQ3] [RQ1]
  // Command receivers only live while powered up and enable registered high
  assign rx_on = (pwr == PWR_ON) && link.cke; // [RQ11] [RQ14]
  assign cmd_ok = rx_on && !link.cs_n; // [RQ4]
  assign is_mrs = cmd_ok && (cmd_code == CMD_MRS);
  assign is_act = cmd_ok && (cmd_code == CMD_ACT);
  assign is_pre = cmd_ok && (cmd_code == CMD_PRE);
  assign is_rd = cmd_ok && (cmd_code == CMD_RD);
  assign is_wr = cmd_ok && (cmd_code == CMD_WR);
  assign no_open = ~|open_banks;
  assign enter_sr = !link.cs_n && (cmd_code == CMD_REF) && no_open;

  // ==========================================
  // Mode-derived controls
  logic [1:0] bl_sel;
  logic chop, rtt_en, tdqs_en, dm_en, x16;
  logic [DQ_W-1:0] wmask;
  assign bl_sel = mode_reg[MR0_IDX][MR0_BL_MSB:MR0_BL_LSB];
  // Address bit 12 only matters when the mode allows on-the-fly choice
  assign chop = (bl_sel == BL_BC4) ||
                ((bl_sel == BL_OTF) && !link.addr[BC_BIT]); // [RQ10] [RQ23]
  assign rtt_en = mode_reg[MR1_IDX][MR1_RTT0] || mode_reg[MR1_IDX][MR1_RTT1] ||
                  mode_reg[MR1_IDX][MR1_RTT2];
  assign tdqs_en = mode_reg[MR1_IDX][MR1_TDQS] && (i_width == WID_X8);
  assign dm_en = !tdqs_en; // [RQ18]
  assign x16 = (i_width == WID_X16);
  assign wmask = (i_width == WID_X4) ? MASK_X4 :
                 (i_width == WID_X8) ? MASK_X8 : MASK_X16; // [RQ19]

  // ==========================================
  // Data path
  logic [2:0] col_lo;
  logic [MEM_AW-1:0] mem_idx;
  logic [DQ_W-1:0] mem_q, bit_we, wr_word;
  logic [LANES-1:0] lane_on, lane_we;
  logic rd_act, wr_act, burst_end;
  assign col_lo = 3'(bcol[2:0] + beat);
  assign mem_idx = {bbank, row_tag[bbank], bcol[4:3], col_lo}; // [RQ8]
  assign mem_q = mem[mem_idx];
  assign lane_on = {x16, 1'b1}; // [RQ22]
  assign rd_act = (bst == B_RD);
  assign wr_act = (bst == B_WR) && (pwr == PWR_ON); // [RQ14]
  assign burst_end = (rd_act || bst == B_WR) && (beat == last);

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // Beat taken while the centred strobe is high; mask drops the byte
      assign lane_we[g] = lane_on[g] && link.dqs[g] &&
                          !(link.dm[g] && dm_en); // [RQ15] [RQ21] [RQ2]
      assign bit_we[g*LANE_W +: LANE_W] = {LANE_W{lane_we[g]}} &
                                          wmask[g*LANE_W +: LANE_W];
    end
  endgenerate
  assign wr_word = (mem_q & ~bit_we) | (link.dq & bit_we);

  // ==========================================
  // Power state
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_ON: begin
        if (!link.cke) begin
          if (enter_sr) next_pwr = PWR_SR; // [RQ12]
          else if (no_open) next_pwr = PWR_PPD; // [RQ12]
          else next_pwr = PWR_APD; // [RQ12]
        end
      end
      PWR_PPD, PWR_APD: begin
        if (link.cke) next_pwr = PWR_ON; // [RQ13]
      end
      PWR_SR: begin
        if (sr_wake) next_pwr = PWR_ON; // [RQ13]
      end
      default: next_pwr = PWR_ON;
    endcase
    if (i_rst) next_pwr = PWR_ON;
  end

  // Enable rising while the clock may be stopped is caught by an async set
  always_ff @(posedge i_clk or posedge link.cke) begin
    if (link.cke) begin
      sr_wake <= 1'b1; // [RQ13]
    end else if (pwr != PWR_SR) begin
      sr_wake <= 1'b0;
    end
  end

  // ==========================================
  // Bank state and burst sequencer
  always_comb begin
    next_open = open_banks;
    if (is_act) next_open[link.ba] = 1'b1; // [RQ5] [RQ8]
    if (is_pre) begin
      if (link.addr[AP_BIT]) next_open = '0; // [RQ6]
      else next_open[link.ba] = 1'b0; // [RQ6]
    end
    if (burst_end && bap) next_open[bbank] = 1'b0; // [RQ5]
    if (i_rst) next_open = '0;
  end

  always_comb begin
    next_bst = bst;
    next_lat = lat;
    next_beat = beat;
    next_last = last;
    next_bbank = bbank;
    next_bcol = bcol;
    next_bap = bap;
    next_bdir = bdir;
    case (bst)
      B_IDLE: begin
        if (is_rd || is_wr) begin
          next_bst = B_WAIT;
          next_lat = is_rd ? RD_LAT - 3'h1 : WR_LAT - 3'h1;
          next_beat = '0;
          next_last = chop ? LAST_BC4 : LAST_BL8; // [RQ10] [RQ23]
          next_bbank = link.ba; // [RQ8]
          next_bcol = link.addr[4:0]; // [RQ5]
          next_bap = link.addr[AP_BIT]; // [RQ5]
          next_bdir = is_rd;
        end
      end
      B_WAIT: begin
        if (lat == '0) next_bst = bdir ? B_RD : B_WR;
        else next_lat = lat - 3'h1;
      end
      B_RD, B_WR: begin
        if (beat == last) next_bst = B_IDLE;
        else next_beat = beat + 3'h1;
      end
      default: next_bst = B_IDLE;
    endcase
    if (i_rst) next_bst = B_IDLE;
  end

  always_ff @(posedge i_clk or negedge link.reset_n) begin
    if (!link.reset_n) begin // [RQ20]
      pwr <= PWR_ON;
      bst <= B_IDLE;
      open_banks <= '0;
      lat <= '0;
      beat <= '0;
      last <= LAST_BL8;
      bbank <= '0;
      bcol <= '0;
      bap <= 1'b0;
      bdir <= 1'b0;
    end else begin
      pwr <= next_pwr;
      bst <= next_bst;
      open_banks <= next_open;
      lat <= next_lat;
      beat <= next_beat;
      last <= next_last;
      bbank <= next_bbank;
      bcol <= next_bcol;
      bap <= next_bap;
      bdir <= next_bdir;
    end
  end

  // ==========================================
  // Mode registers and row tags
  always_ff @(posedge i_clk or negedge link.reset_n) begin
    if (!link.reset_n) begin // [RQ20]
      for (int i = 0; i < NMR; i++) mode_reg[i] <= '0;
      row_tag <= '0;
    end else if (i_rst) begin
      for (int i = 0; i < NMR; i++) mode_reg[i] <= '0;
      row_tag <= '0;
    end else begin
      if (is_mrs) mode_reg[link.ba[1:0]] <= link.addr; // [RQ7] [RQ9]
      if (is_act) row_tag[link.ba] <= link.addr[0]; // [RQ5]
    end
  end

  // Array content is not cleared; a reset does not wipe stored data
  always_ff @(posedge i_clk) begin
    if (wr_act) mem[mem_idx] <= wr_word;
  end

  // ==========================================
  // Read drive and termination
  always_ff @(posedge i_clk or negedge link.reset_n) begin
    if (!link.reset_n) begin // [RQ20]
      link.d_dq <= '0;
      link.d_dq_oe_n <= '1;
      link.d_dqs <= '0;
      link.d_dqs_oe_n <= '1;
      term_q <= 1'b0;
      tdqs_q <= 1'b0;
    end else begin
      link.d_dq <= rd_act ? (mem_q & wmask) : '0; // [RQ19]
      link.d_dq_oe_n <= rd_act ? ~wmask : '1;
      // Strobe flips with each beat, so its edges line up with data
      link.d_dqs <= (rd_act && !beat[0]) ? lane_on : '0; // [RQ2] [RQ1]
      link.d_dqs_oe_n <= rd_act ? ~lane_on : '1; // [RQ22]
      // Termination receiver stays on in power-down, off in self refresh
      term_q <= !i_rst && (pwr != PWR_SR) && rtt_en && link.odt; // [RQ16] [RQ17] [RQ14]
      tdqs_q <= !i_rst && (pwr != PWR_SR) && rtt_en && link.odt && tdqs_en; // [RQ18]
    end
  end

  assign o_pwr = pwr;
  assign o_open_banks = open_banks;
  assign o_term_on = term_q;
  assign o_tdqs_term = tdqs_q;
endmodule

// >>> dv/dci_assertions.sv
// Concurrent checks on the link between controller and device
module dci_assertions
  import dci_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] d_dq_oe_n,
  input wire logic [LANES-1:0] d_dqs,
  input wire logic [LANES-1:0] d_dqs_oe_n,
  input wire dci_pwr_t o_pwr,
  input wire logic [NBANK-1:0] o_open_banks,
  input wire logic o_term_on
);
  // ====================
  // Decode helpers
  wire logic [3:0] cmd;
  wire logic live;
  wire logic pwr_down;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign live = reset_n && cke && o_pwr == PWR_ON;
  assign pwr_down = o_pwr == PWR_PPD || o_pwr == PWR_APD;
  // Link reset clears the device too, so it gates every check
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !reset_n);
  sequence s_read_taken;
    live && cmd == CMD_RD;
  endsequence
  sequence s_first_beat;
    ##[1:5] !d_dq_oe_n[0];
  endsequence
  // ====================
  // Command decode
  AST_CS_MASK: assert property (cs_n |=> (o_open_banks & ~$past(o_open_banks)) == '0)
    else $error("bank opened with chip select high");
  AST_ACT_OPEN: assert property (live && cmd == CMD_ACT |=> o_open_banks[$past(ba)])
    else $error("activate missed its bank");
  AST_PRE_ONE: assert property (live && cmd == CMD_PRE && !addr[AP_BIT]
    |=> o_open_banks == ($past(o_open_banks) & ~(8'h01 << $past(ba))))
    else $error("single precharge hit wrong banks");
  AST_PRE_ALL: assert property (live && cmd == CMD_PRE && addr[AP_BIT] |=> o_open_banks == '0)
    else $error("precharge all left a bank open");
  // ====================
  // Clock enable and power states
  AST_APD: assert property (o_pwr == PWR_ON && !cke && o_open_banks != '0
    |=> o_pwr == PWR_APD) else $error("no active power-down");
  AST_PPD: assert property (o_pwr == PWR_ON && !cke && o_open_banks == '0 && cmd != CMD_REF
    |=> o_pwr == PWR_PPD) else $error("no precharge power-down");
  AST_PD_EXIT: assert property (pwr_down && cke |=> o_pwr == PWR_ON)
    else $error("power-down exit missed");
  AST_PD_HOLD: assert property (pwr_down && !cke |=> $stable(o_open_banks))
    else $error("command taken in power-down");
  AST_TERM_OFF: assert property (!odt || o_pwr == PWR_SR |=> !o_term_on)
    else $error("termination on without enable");
  // ====================
  // Read data and strobe
  AST_RD_LAT: assert property (s_read_taken |-> s_first_beat)
    else $error("read data late");
  AST_RD_FIRST: assert property ($fell(d_dq_oe_n[0]) |-> !d_dqs_oe_n[0] && d_dqs[0])
    else $error("read strobe not edge aligned");
  AST_RD_TOGGLE: assert property (!d_dqs_oe_n[0] && $past(d_dqs_oe_n[0]) == 1'b0
    |-> d_dqs[0] != $past(d_dqs[0])) else $error("read strobe stuck");
endmodule

// >>> dv/dci_test.sv
// Self-checking bench: controller and device joined over the link
module dci_test
  import dci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
  typedef struct packed {
    logic [2:0] bank;
    logic [1:0] blen;
    logic chop_a12;
    logic close;
    logic [1:0] mask;
    logic [15:0] wd;
    logic [15:0] exp;
    logic [3:0] beats;
  } dci_row_t;
  dci_row_t rows [6] = '{
    '{3'h0, 2'h0, 1'b0, 1'b0, 2'h0, 16'h1111, 16'h1111, 4'h8},
    '{3'h7, 2'h1, 1'b1, 1'b1, 2'h0, 16'h7007, 16'h7007, 4'h8},
    '{3'h3, 2'h1, 1'b0, 1'b0, 2'h0, 16'h3003, 16'h3003, 4'h4},
    '{3'h5, 2'h2, 1'b1, 1'b1, 2'h0, 16'h5005, 16'h5005, 4'h4},
    '{3'h0, 2'h0, 1'b0, 1'b0, 2'h1, 16'h2222, 16'h2211, 4'h8},
    '{3'h0, 2'h0, 1'b0, 1'b0, 2'h2, 16'h3333, 16'h2233, 4'h8}};
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata;
  logic [31:0] got;
  dci_width_t i_width = WID_X16;
  dci_pwr_t o_pwr;
  logic [NBANK-1:0] o_open_banks;
  logic o_term_on;
  logic o_tdqs_term;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  dci_if link_if ();
  dci_ctrl u_dci_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link_if.ctl));
  dci_device u_dci_device (.i_clk(i_clk), .i_rst(i_rst), .i_width(i_width),
    .link(link_if.dev), .o_pwr(o_pwr), .o_open_banks(o_open_banks),
    .o_term_on(o_term_on), .o_tdqs_term(o_tdqs_term));
  dci_assertions u_dci_assertions (.i_clk(i_clk), .i_rst(i_rst), .reset_n(link_if.reset_n),
    .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n),
    .we_n(link_if.we_n), .odt(link_if.odt), .ba(link_if.ba), .addr(link_if.addr),
    .d_dq_oe_n(link_if.d_dq_oe_n), .d_dqs(link_if.d_dqs), .d_dqs_oe_n(link_if.d_dqs_oe_n),
    .o_pwr(o_pwr), .o_open_banks(o_open_banks), .o_term_on(o_term_on));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ====================
  // Register port and link tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    wr(REG_ADDR, {13'h0, b, 2'h0, a});
    wr(REG_CMD, {28'h0, c});
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic set_ctrl(input logic [4:0] v);
    wr(REG_CTRL, {27'h0, v});
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // Full write burst then read back of its first beat
  task automatic xfer(input dci_row_t r);
    cmd(CMD_MRS, {1'b0, MR0_IDX}, {12'h000, r.blen});
    set_ctrl({r.mask, 3'h5});
    wr(REG_WDATA, {16'h0000, r.wd});
    cmd(CMD_ACT, r.bank, 14'h0000);
    cmd(CMD_WR, r.bank, {1'b0, r.chop_a12, 12'h000});
    repeat (12) @(posedge i_clk);
    cmd(CMD_RD, r.bank, {1'b0, r.chop_a12, 1'b0, r.close, 10'h000});
    got = 32'h0;
    for (int k = 0; k < 30 && got[STAT_DONE] !== 1'b1; k++) rd(REG_STATUS);
    `CHK(got[STAT_DONE], 1'b1)
    rd(REG_RDATA);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ====================
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(REG_CTRL);
    `CHK(got, 32'h0)
    set_ctrl(5'h05);
    foreach (rows[i]) begin
      xfer(rows[i]);
      `CHK(got[15:0], rows[i].exp)
      `CHK(got[19:16], rows[i].beats)
      `CHK(o_open_banks[rows[i].bank], ~rows[i].close)
    end
    cmd(CMD_PRE, 3'h0, 14'h0400);
    `CHK(o_open_banks, 8'h00)
    cmd(CMD_ACT | 4'h8, 3'h2, 14'h0000);
    `CHK(o_open_banks, 8'h00)
    cmd(CMD_ACT, 3'h1, 14'h0000);
    cmd(CMD_ACT, 3'h6, 14'h0000);
    `CHK(o_open_banks, 8'h42)
    cmd(CMD_PRE, 3'h1, 14'h0000);
    `CHK(o_open_banks, 8'h40)
    set_ctrl(5'h04);
    `CHK(o_pwr, PWR_APD)
    cmd(CMD_ACT, 3'h3, 14'h0000);
    `CHK(o_open_banks, 8'h40)
    set_ctrl(5'h05);
    `CHK(o_pwr, PWR_ON)
    cmd(CMD_PRE, 3'h0, 14'h0400);
    set_ctrl(5'h04);
    `CHK(o_pwr, PWR_PPD)
    set_ctrl(5'h05);
    `CHK(o_pwr, PWR_ON)
    // Refresh command in the cycle enable drops, all banks idle
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= REG_CTRL;
    i_wdata <= 32'h0000_0004;
    @(posedge i_clk);
    i_addr <= REG_CMD;
    i_wdata <= {28'h000_0000, CMD_REF};
    @(posedge i_clk);
    i_wr <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_pwr, PWR_SR)
    set_ctrl(5'h05);
    `CHK(o_pwr, PWR_ON)
    cmd(CMD_MRS, {1'b0, MR1_IDX}, 14'h0004);
    set_ctrl(5'h07);
    `CHK(o_term_on, 1'b1)
    set_ctrl(5'h05);
    `CHK(o_term_on, 1'b0)
    cmd(CMD_MRS, {1'b0, MR1_IDX}, 14'h0000);
    set_ctrl(5'h07);
    `CHK(o_term_on, 1'b0)
    // Eight-bit part with strobe termination: mask must not bite
    @(posedge i_clk);
    i_width <= WID_X8;
    cmd(CMD_MRS, {1'b0, MR1_IDX}, 14'h0804);
    xfer('{3'h0, 2'h0, 1'b1, 1'b0, 2'h1, 16'h0044, 16'h0044, 4'h8});
    `CHK(got[15:0], 16'h0044)
    set_ctrl(5'h0F);
    `CHK(o_tdqs_term, 1'b1)
    @(posedge i_clk);
    i_width <= WID_X4;
    cmd(CMD_MRS, {1'b0, MR1_IDX}, 14'h0000);
    xfer('{3'h0, 2'h0, 1'b0, 1'b0, 2'h0, 16'hABF5, 16'h0005, 4'h8});
    `CHK(got[15:0], 16'h0005)
    @(posedge i_clk);
    i_width <= WID_X16;
    cmd(CMD_ACT, 3'h4, 14'h0000);
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_open_banks, 8'h00)
    set_ctrl(5'h05);
    rd(8'hFC);
    `CHK(got, 32'h0)
    rd(REG_CMD);
    `CHK(got, 32'h0)
    cmd(CMD_ACT, 3'h2, 14'h0000);
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK({link_if.cs_n, link_if.reset_n, link_if.cke}, 3'b100)
    `CHK(o_open_banks, 8'h00)
    `CHK(o_pwr, PWR_ON)
    tally_and_finish();
  end
endmodule
